// ==== inc/serial_pkg.sv ====
/*
 Constants shared by the serial status, loop and stop-mode block:
 register offsets, status bit positions, reset values, timing counts.
 Assumes a 125 MHz bus clock and 16 samples per bit.
*/
package serial_pkg;
	localparam logic [7:0] OFS_STATUS_ONE  = 8'h00;
	localparam logic [7:0] OFS_DATA        = 8'h04;
	localparam logic [7:0] OFS_CONTROL_ONE = 8'h08;
	localparam logic [7:0] OFS_CONTROL_THR = 8'h0C;
	localparam logic [7:0] OFS_IRQ_STATUS  = 8'h10;
	localparam logic [7:0] OFS_IRQ_MASK    = 8'h14;
	localparam logic [7:0] OFS_STOP_CTRL   = 8'h18;
	localparam logic [7:0] OFS_BAUD        = 8'h1C;

	// serial_status_one bit positions
	localparam int ST_RX_FULL = 5;
	localparam int ST_OVERRUN = 3;
	localparam int ST_NOISE   = 2;

	// serial_control_three bit positions
	localparam int C3_LOOP  = 7;
	localparam int C3_RECEIVER_SOURCE_SELECT  = 6;
	localparam int C3_SINGLE_WIRE_DIRECTION = 5;
	localparam int C3_EDGIE = 4;

	// Interrupt status / mask bit positions
	localparam int IRQ_RX_FULL = 0;
	localparam int IRQ_OVERRUN = 1;
	localparam int IRQ_NOISE   = 2;
	localparam int IRQ_EDGE    = 3;
	localparam int IRQ_TX_DONE = 4;

	// Stop control encodings
	localparam logic [1:0] STOP_RUN   = 2'h0;
	localparam logic [1:0] STOP_LIGHT = 2'h3;
	localparam logic [1:0] STOP_MID   = 2'h2;
	localparam logic [1:0] STOP_DEEP  = 2'h1;

	localparam int          OVERSAMPLE   = 16;
	localparam logic [15:0] BAUD_RESET   = 16'h0044;
	localparam logic [7:0]  CTRL_RESET   = 8'h00;
	localparam int          DATA_BITS    = 8;
	localparam int          START_SAMPLES = 7;
	localparam int          BIT_SAMPLES   = 3;
endpackage : serial_pkg

// ==== rtl/serial_loop_status.sv ====
/*
 Serial receiver/transmitter core with overrun and noise status,
 stop-mode handling, internal loop and single-wire modes, behind an
 AHB-Lite slave. Assumes one clock, all inputs synchronous to it.
*/
//
// Overview of operation
// - Overrun when new char meets unread data
// - Overrun clears by status read, data read
// - Seven start samples, three per bit
// - Noise flag set with receive-full flag
// - Noise clears by status then data read
// - Stop modes freeze shifting; mid and deep stops clear flags
// - Mid and deep stops lose registers; light keeps them
// - Edge detector wakes in light stop only
// - Resume from held state after light stop
// - Loop select plus source picks mode
// - Loop mode feeds transmitter to receiver
// - Single-wire joins receiver, transmitter, pin
// - Direction zero: pin is receiver input
// - Direction one: transmitter drives pin
// - Single-wire receiver hears own transmission at direction one
// - Receive-full set on shifter-to-data move
`timescale 1ns/1ps
module serial_loop_status
	import serial_pkg::*;
(
	input  wire logic        ref_clk_i,
	input  wire logic        nrst_i,
	input  wire logic [31:0] haddr_i,
	input  wire logic [1:0]  htrans_i,
	input  wire logic        hwrite_i,
	input  wire logic [2:0]  hsize_i,
	input  wire logic        hsel_i,
	input  wire logic        hready_i,
	input  wire logic [31:0] hwdata_i,
	output logic      [31:0] hrdata_o,
	output logic             hreadyout_o,
	output logic             hresp_o,
	input  wire logic        rxd_i,
	input  wire logic        txd_pin_i,
	output logic             txd_pin_o,
	output logic             txd_pin_oe_o,
	output logic             rx_pin_released_o,
	output logic             wake_o,
	output logic             irq_o
);
	typedef enum logic [1:0] {RX_IDLE = 2'b00, RX_START = 2'b01, RX_DATA = 2'b11,
		RX_STOP = 2'b10} rx_state_type;
	typedef enum logic [1:0] {TX_IDLE = 2'b00, TX_START = 2'b01, TX_DATA = 2'b11,
		TX_STOP = 2'b10} tx_state_type;

	logic [7:0]   control_one;
	logic [7:0]   control_three;
	logic [15:0]  baud;
	logic [1:0]   stop_mode;
	logic [4:0]   irq_status;
	logic [4:0]   irq_mask;
	logic [7:0]   rx_data;
	logic         rx_full;
	logic         overrun;
	logic         noise;
	logic         status_armed;
	logic         ph_valid;
	logic         ph_write;
	logic [7:0]   ph_addr;
	logic         run;
	logic         wipe;
	logic [15:0]  div_cnt;
	logic         tick;
	rx_state_type rx_state;
	logic [3:0]   rx_smp;
	logic [2:0]   rx_bit;
	logic [7:0]   rx_shift;
	logic         rx_noise;
	logic [2:0]   votes;
	logic         rx_done;
	logic [7:0]   rx_word;
	logic         rx_word_noise;
	tx_state_type tx_state;
	logic [3:0]   tx_smp;
	logic [2:0]   tx_bit;
	logic [7:0]   tx_shift;
	logic         tx_line;
	logic         tx_pending;
	logic [7:0]   tx_hold;
	logic         tx_done;
	logic         loop_mode;
	logic         wire_mode;
	logic         rx_line;
	logic         rx_prev;
	logic         edge_seen;
	logic         data_read;
	logic         status_read;
	logic         next_noisy;
	logic [1:0]   vote_sum;

	// Only the light stop keeps the clock path notionally alive for wake-up
	assign run  = (stop_mode == STOP_RUN);
	assign wipe = (stop_mode == STOP_DEEP) || (stop_mode == STOP_MID);

	assign loop_mode = control_three[C3_LOOP] && !control_three[C3_RECEIVER_SOURCE_SELECT];
	assign wire_mode = control_three[C3_LOOP] && control_three[C3_RECEIVER_SOURCE_SELECT];
	always_comb begin
		if (loop_mode)
			rx_line = tx_line;
		else if (wire_mode)
			rx_line = control_three[C3_SINGLE_WIRE_DIRECTION] ? tx_line : txd_pin_i;
		else
			rx_line = rxd_i;
	end

	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			txd_pin_o         <= 1'b1;
			txd_pin_oe_o      <= 1'b1;
			rx_pin_released_o <= 1'b0;
		end else begin
			txd_pin_o         <= tx_line;
			txd_pin_oe_o      <= !wire_mode || control_three[C3_SINGLE_WIRE_DIRECTION];
			rx_pin_released_o <= control_three[C3_LOOP];
		end
	end

	// AHB-Lite address phase capture
	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			ph_valid <= 1'b0;
			ph_write <= 1'b0;
			ph_addr  <= 8'h00;
		end else if (hready_i) begin
			ph_valid <= hsel_i && htrans_i[1];
			ph_write <= hwrite_i;
			ph_addr  <= haddr_i[7:0];
		end
	end
	assign data_read   = ph_valid && !ph_write && ph_addr == OFS_DATA;
	assign status_read = ph_valid && !ph_write && ph_addr == OFS_STATUS_ONE;

	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			hreadyout_o <= 1'b1;
			hresp_o     <= 1'b0;
			hrdata_o    <= 32'h0000_0000;
		end else begin
			hreadyout_o <= 1'b1;
			hresp_o     <= 1'b0;
			hrdata_o    <= 32'h0000_0000;
			if (hready_i && hsel_i && htrans_i[1] && !hwrite_i) begin
				case (haddr_i[7:0])
					OFS_STATUS_ONE:  hrdata_o[7:0] <= {2'h0, rx_full, 1'b0, overrun, noise, 2'h0};
					OFS_DATA:        hrdata_o[7:0] <= rx_data;
					OFS_CONTROL_ONE: hrdata_o[7:0] <= control_one;
					OFS_CONTROL_THR: hrdata_o[7:0] <= control_three;
					OFS_IRQ_STATUS:  hrdata_o[4:0] <= irq_status;
					OFS_IRQ_MASK:    hrdata_o[4:0] <= irq_mask;
					OFS_STOP_CTRL:   hrdata_o[1:0] <= stop_mode;
					OFS_BAUD:        hrdata_o[15:0] <= baud;
					default:         hrdata_o <= 32'h0000_0000;
				endcase
			end
		end
	end

	// Stop control lives outside the wiped set so software can leave stop
	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i)
			stop_mode <= STOP_RUN;
		else if (ph_valid && ph_write && ph_addr == OFS_STOP_CTRL)
			stop_mode <= hwdata_i[1:0];
		else if (stop_mode == STOP_LIGHT && edge_seen && control_three[C3_EDGIE])
			stop_mode <= STOP_RUN;
	end

	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			control_one   <= CTRL_RESET;
			control_three <= CTRL_RESET;
			baud          <= BAUD_RESET;
			irq_mask      <= 5'h00;
			tx_hold       <= 8'h00;
			tx_pending    <= 1'b0;
		end else if (wipe) begin
			control_one   <= CTRL_RESET;
			control_three <= CTRL_RESET;
			baud          <= BAUD_RESET;
			irq_mask      <= 5'h00;
			tx_pending    <= 1'b0;
		end else if (run) begin
			if (tx_state == TX_IDLE && tx_pending && tick)
				tx_pending <= 1'b0;
			if (ph_valid && ph_write) begin
				case (ph_addr)
					OFS_DATA: begin
						tx_hold    <= hwdata_i[7:0];
						tx_pending <= 1'b1;
					end
					OFS_CONTROL_ONE: control_one   <= hwdata_i[7:0];
					OFS_CONTROL_THR: control_three <= hwdata_i[7:0];
					OFS_IRQ_MASK:    irq_mask      <= hwdata_i[4:0];
					OFS_BAUD:        baud          <= hwdata_i[15:0];
					default:         ;
				endcase
			end
		end
	end

	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			div_cnt <= 16'h0000;
			tick    <= 1'b0;
		end else if (!run) begin
			tick <= 1'b0;
		end else if (div_cnt >= baud) begin
			div_cnt <= 16'h0000;
			tick    <= 1'b1;
		end else begin
			div_cnt <= div_cnt + 16'h0001;
			tick    <= 1'b0;
		end
	end

	assign vote_sum   = 2'(votes[0]) + 2'(votes[1]) + 2'(votes[2]);
	assign next_noisy = (vote_sum != 2'h0) && (vote_sum != 2'h3);

	// Samples 7..9 of each bit; a start bit adds samples 3..6 of its front half
	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			rx_state      <= RX_IDLE;
			rx_smp        <= 4'h0;
			rx_bit        <= 3'h0;
			rx_shift      <= 8'h00;
			rx_noise      <= 1'b0;
			votes         <= 3'h0;
			rx_done       <= 1'b0;
			rx_word       <= 8'h00;
			rx_word_noise <= 1'b0;
		end else if (wipe) begin
			rx_state <= RX_IDLE;
			rx_done  <= 1'b0;
		end else begin
			rx_done <= 1'b0;
			// A tick already registered when stop lands must not step the shifter
			if (tick && run) begin
				rx_smp <= rx_smp + 4'h1;
				case (rx_state)
					RX_IDLE: begin
						rx_smp   <= 4'h1;
						rx_noise <= 1'b0;
						if (!rx_line)
							rx_state <= RX_START;
					end
					RX_START: begin
						if (rx_smp >= 4'h3 && rx_smp <= 4'h6)
							rx_noise <= rx_noise | rx_line;
						if (rx_smp >= 4'h7 && rx_smp <= 4'h9)
							votes <= {votes[1:0], rx_line};
						if (rx_smp == 4'hA) begin
							rx_noise <= rx_noise | next_noisy;
							if (vote_sum >= 2'h2)
								rx_state <= RX_IDLE;
						end
						if (rx_smp == 4'hF) begin
							rx_state <= RX_DATA;
							rx_bit   <= 3'h0;
						end
					end
					RX_DATA, RX_STOP: begin
						if (rx_smp >= 4'h7 && rx_smp <= 4'h9)
							votes <= {votes[1:0], rx_line};
						if (rx_smp == 4'hA) begin
							rx_noise <= rx_noise | next_noisy;
							if (rx_state == RX_DATA)
								rx_shift <= {vote_sum >= 2'h2, rx_shift[7:1]};
						end
						if (rx_smp == 4'hF) begin
							if (rx_state == RX_STOP) begin
								rx_state      <= RX_IDLE;
								rx_done       <= 1'b1;
								rx_word       <= rx_shift;
								rx_word_noise <= rx_noise;
							end else if (rx_bit == 3'(DATA_BITS - 1)) begin
								rx_state <= RX_STOP;
							end else begin
								rx_bit <= rx_bit + 3'h1;
							end
						end
					end
					default: rx_state <= RX_IDLE;
				endcase
			end
		end
	end

	// Status read with a flag set arms the clear; a later data read completes it
	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			rx_full      <= 1'b0;
			overrun      <= 1'b0;
			noise        <= 1'b0;
			rx_data      <= 8'h00;
			status_armed <= 1'b0;
		end else if (wipe) begin
			rx_full      <= 1'b0;
			overrun      <= 1'b0;
			noise        <= 1'b0;
			status_armed <= 1'b0;
		end else begin
			if (status_read)
				status_armed <= rx_full || overrun || noise;
			if (data_read && status_armed) begin
				status_armed <= 1'b0;
				rx_full      <= 1'b0;
				overrun      <= 1'b0;
				noise        <= 1'b0;
			end
			if (rx_done) begin
				if (rx_full && !(data_read && status_armed)) begin
					overrun <= 1'b1;
				end else begin
					rx_data <= rx_word;
					rx_full <= 1'b1;
					noise   <= rx_word_noise;
				end
			end
		end
	end

	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			tx_state <= TX_IDLE;
			tx_smp   <= 4'h0;
			tx_bit   <= 3'h0;
			tx_shift <= 8'h00;
			tx_line  <= 1'b1;
			tx_done  <= 1'b0;
		end else if (wipe) begin
			tx_state <= TX_IDLE;
			tx_line  <= 1'b1;
			tx_done  <= 1'b0;
		end else begin
			tx_done <= 1'b0;
			if (tick && run) begin
				tx_smp <= tx_smp + 4'h1;
				case (tx_state)
					TX_IDLE: if (tx_pending) begin
						tx_state <= TX_START;
						tx_shift <= tx_hold;
						tx_smp   <= 4'h1;
						tx_line  <= 1'b0;
					end
					TX_START: if (tx_smp == 4'hF) begin
						tx_state <= TX_DATA;
						tx_bit   <= 3'h0;
						tx_line  <= tx_shift[0];
					end
					TX_DATA: if (tx_smp == 4'hF) begin
						tx_shift <= {1'b1, tx_shift[7:1]};
						if (tx_bit == 3'(DATA_BITS - 1)) begin
							tx_state <= TX_STOP;
							tx_line  <= 1'b1;
						end else begin
							tx_bit  <= tx_bit + 3'h1;
							tx_line <= tx_shift[1];
						end
					end
					TX_STOP: if (tx_smp == 4'hF) begin
						tx_state <= TX_IDLE;
						tx_done  <= 1'b1;
					end
					default: tx_state <= TX_IDLE;
				endcase
			end
		end
	end

	// Edge detector runs in run and light stop only
	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			rx_prev   <= 1'b1;
			edge_seen <= 1'b0;
			wake_o    <= 1'b0;
		end else begin
			rx_prev   <= rx_line;
			edge_seen <= (run || stop_mode == STOP_LIGHT) && rx_prev && !rx_line;
			wake_o    <= stop_mode == STOP_LIGHT && edge_seen && control_three[C3_EDGIE];
		end
	end

	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			irq_status <= 5'h00;
			irq_o      <= 1'b0;
		end else if (wipe) begin
			irq_status <= 5'h00;
			irq_o      <= 1'b0;
		end else begin
			// Set beats a simultaneous write-one clear
			irq_status <= (irq_status & ~((ph_valid && ph_write && ph_addr == OFS_IRQ_STATUS)
				? hwdata_i[4:0] : 5'h00))
				| {tx_done, edge_seen, rx_done && rx_word_noise, rx_done && rx_full,
				rx_done};
			irq_o <= |(irq_status & irq_mask);
		end
	end

	AST_OVERRUN_KEEPS_DATA: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
		rx_done && rx_full && !data_read && !wipe |=> overrun && $stable(rx_data))
		else $error("overrun not flagged or data overwritten");
	AST_OVERRUN_CLEAR: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
		$fell(overrun) && !$past(wipe) |-> $past(data_read && status_armed))
		else $error("overrun cleared without data read");
	AST_NOISE_CLEAR: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
		$fell(noise) && !$past(wipe) |-> $past(data_read && status_armed))
		else $error("noise cleared without read sequence");
	AST_NOISE_WITH_FULL: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
		$rose(noise) |-> rx_full && $past(rx_done))
		else $error("noise set apart from receive full");
	AST_FULL_ON_DONE: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
		rx_done && !rx_full && !wipe |=> rx_full && rx_data == $past(rx_word))
		else $error("receive full not set on transfer");
	AST_STOP_FREEZE: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
		!run ##1 !run |-> $stable(rx_state) && $stable(tx_line))
		else $error("shifting during stop");
	AST_DEEP_WIPE: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
		wipe |=> control_three == CTRL_RESET && !rx_full)
		else $error("deep stop kept register state");
	AST_WAKE_LIGHT: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
		wake_o |-> $past(stop_mode) == STOP_LIGHT ##1 run)
		else $error("wake outside light stop or no resume");
	AST_PIN_DIR: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
		wire_mode |=> txd_pin_oe_o == $past(control_three[C3_SINGLE_WIRE_DIRECTION]))
		else $error("single-wire direction not applied");
	AST_LOOP_ROUTE: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
		loop_mode |-> rx_line == tx_line)
		else $error("loop mode not routing transmitter");
	AST_WIRE_ECHO: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
		wire_mode && control_three[C3_SINGLE_WIRE_DIRECTION] |-> rx_line == tx_line)
		else $error("single-wire echo missing");
endmodule : serial_loop_status

// ==== verification/remote_serial.sv ====
/*
 Remote serial device on the line side: sends 8N1 frames, optionally
 with a short glitch, and can hold the line low for a wake edge.
 Assumes the bench gives the bit length in clock cycles.
*/
`timescale 1ns/1ps
module remote_serial (
	input  wire logic ref_clk_i,
	output logic      line_o
);
	initial line_o = 1'h1;

	// Only called while the block runs, never across a stop request
	task automatic send(input logic [7:0] b, input int bit_cyc, input bit glitch);
		logic [9:0] f;
		f = {1'h1, b, 1'h0};
		for (int i = 0; i < 10; i++) begin
			for (int c = 0; c < bit_cyc; c++) begin
				@(posedge ref_clk_i);
				// Flip hits one mid-bit sample only, so the majority still holds
				line_o <= f[i] ^ (glitch && i == 3 && (c == 16 || c == 17));
			end
		end
	endtask : send

	task automatic pulse_low(input int n);
		@(posedge ref_clk_i);
		line_o <= 1'h0;
		repeat (n) @(posedge ref_clk_i);
		line_o <= 1'h1;
	endtask : pulse_low
endmodule : remote_serial

// ==== verification/async_serial_status_loop_modes_tb.sv ====
/*
 Self-checking bench for the serial status, loop and stop-mode block.
 Assumes an AHB-Lite single master and the remote serial model.
*/
`timescale 1ns/1ps
module async_serial_status_loop_modes_tb
	import serial_pkg::*;
;
	logic        ref_clk     = 1'h0;
	logic        nrst        = 1'h0;
	logic [31:0] haddr       = 32'h0;
	logic [1:0]  htrans      = 2'h0;
	logic        hwrite      = 1'h0;
	logic [31:0] hwdata      = 32'h0;
	logic        route_pin   = 1'h0;
	logic        woke        = 1'h0;
	int          fails       = 0;
	int          checks_done = 0;
	int          cycles      = 0;
	wire  [31:0] hrdata;
	wire         hreadyout;
	wire         hresp;
	wire         txd_o;
	wire         txd_oe;
	wire         released;
	wire         wake;
	wire         irq;
	wire         remote_line;
	// Pull-up keeps an undriven pin at mark level
	wire         rx_line  = route_pin ? 1'h1 : remote_line;
	wire         pin_line = txd_oe ? txd_o : (route_pin ? remote_line : 1'h1);

	always #4 ref_clk = ~ref_clk;

	serial_loop_status i_serial_loop_status (
		.ref_clk_i(ref_clk), .nrst_i(nrst), .haddr_i(haddr), .htrans_i(htrans),
		.hwrite_i(hwrite), .hsize_i(3'h2), .hsel_i(1'h1), .hready_i(hreadyout),
		.hwdata_i(hwdata), .hrdata_o(hrdata), .hreadyout_o(hreadyout), .hresp_o(hresp),
		.rxd_i(rx_line), .txd_pin_i(pin_line), .txd_pin_o(txd_o), .txd_pin_oe_o(txd_oe),
		.rx_pin_released_o(released), .wake_o(wake), .irq_o(irq)
	);

	remote_serial i_remote_serial (.ref_clk_i(ref_clk), .line_o(remote_line));

	always @(posedge ref_clk) begin
		cycles <= cycles + 1;
		if (wake === 1'h1) woke <= 1'h1;
		if (cycles == 40000) begin
			fails = fails + 1;
			complete_run();
		end
	end

	task automatic complete_run();
		$display("checks %0d mismatches %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask : complete_run

	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		checks_done++;
		if (g !== e) begin
			$display("unexpected %s: expected %h seen %h", n, e, g);
			fails++;
		end
	endtask : chk

	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd,
			output logic [31:0] rd);
		@(posedge ref_clk);
		haddr <= {24'h0, a};
		htrans <= 2'h2;
		hwrite <= w;
		do @(posedge ref_clk); while (hreadyout !== 1'h1);
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge ref_clk); while (hreadyout !== 1'h1);
		rd = hrdata;
	endtask : bus

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] x;
		bus(1'h1, a, d, x);
	endtask : wr

	task automatic rd_chk(input string n, input logic [7:0] a, input logic [31:0] e);
		logic [31:0] x;
		bus(1'h0, a, 32'h0, x);
		chk(n, e, x);
	endtask : rd_chk

	task automatic wait_bit(input logic [7:0] a, input int b);
		logic [31:0] x;
		int n;
		n = 0;
		do begin
			bus(1'h0, a, 32'h0, x);
			n++;
		end while (x[b] !== 1'h1 && n < 400);
		chk("poll bit", 32'h1, {31'h0, x[b]});
	endtask : wait_bit

	task automatic settle();
		repeat (3) @(posedge ref_clk);
	endtask : settle

	task automatic test_reset();
		rd_chk("status", OFS_STATUS_ONE, 32'h0);
		rd_chk("control three", OFS_CONTROL_THR, 32'h0);
		rd_chk("baud", OFS_BAUD, {16'h0, BAUD_RESET});
		rd_chk("unmapped", 8'h40, 32'h0);
		chk("txd idle", 32'h1, {31'h0, txd_o});
		chk("response okay", 32'h0, {31'h0, hresp});
		wr(OFS_BAUD, 32'h1);
		$display("test reset done");
	endtask : test_reset

	task automatic test_receive();
		logic [31:0] x;
		wr(OFS_IRQ_MASK, 32'h0);
		i_remote_serial.send(8'hA5, 32, 1'b0);
		wait_bit(OFS_STATUS_ONE, ST_RX_FULL);
		rd_chk("status full", OFS_STATUS_ONE, 32'h20);
		bus(1'h0, OFS_IRQ_STATUS, 32'h0, x);
		chk("irq status", 32'h1, {31'h0, x[IRQ_RX_FULL]});
		chk("irq masked", 32'h0, {31'h0, irq});
		wr(OFS_IRQ_MASK, 32'h1 << IRQ_RX_FULL);
		settle();
		chk("irq raised", 32'h1, {31'h0, irq});
		wr(OFS_IRQ_STATUS, 32'hFF);
		settle();
		chk("irq cleared", 32'h0, {31'h0, irq});
		rd_chk("data", OFS_DATA, 32'hA5);
		rd_chk("status cleared", OFS_STATUS_ONE, 32'h0);
		$display("test receive done");
	endtask : test_receive

	task automatic test_overrun();
		i_remote_serial.send(8'h11, 32, 1'b0);
		i_remote_serial.send(8'h22, 32, 1'b0);
		wait_bit(OFS_IRQ_STATUS, IRQ_OVERRUN);
		rd_chk("status overrun", OFS_STATUS_ONE, 32'h28);
		rd_chk("first kept", OFS_DATA, 32'h11);
		rd_chk("overrun cleared", OFS_STATUS_ONE, 32'h0);
		wr(OFS_IRQ_STATUS, 32'hFF);
		$display("test overrun done");
	endtask : test_overrun

	task automatic test_noise();
		i_remote_serial.send(8'hC3, 32, 1'b1);
		wait_bit(OFS_STATUS_ONE, ST_RX_FULL);
		rd_chk("status noise", OFS_STATUS_ONE, 32'h24);
		rd_chk("majority data", OFS_DATA, 32'hC3);
		rd_chk("noise cleared", OFS_STATUS_ONE, 32'h0);
		$display("test noise done");
	endtask : test_noise

	task automatic test_loop();
		route_pin <= 1'h1;
		wr(OFS_CONTROL_THR, 32'h80);
		settle();
		chk("rx released", 32'h1, {31'h0, released});
		wr(OFS_DATA, 32'h3C);
		wait_bit(OFS_STATUS_ONE, ST_RX_FULL);
		rd_chk("loop data", OFS_DATA, 32'h3C);
		wr(OFS_CONTROL_THR, 32'hE0);
		settle();
		chk("pin driven", 32'h1, {31'h0, txd_oe});
		wr(OFS_DATA, 32'h5A);
		repeat (6) @(posedge ref_clk);
		chk("pin start bit", 32'h0, {31'h0, txd_o});
		wait_bit(OFS_STATUS_ONE, ST_RX_FULL);
		rd_chk("own echo", OFS_DATA, 32'h5A);
		wr(OFS_CONTROL_THR, 32'hC0);
		settle();
		chk("pin released", 32'h0, {31'h0, txd_oe});
		i_remote_serial.send(8'h96, 32, 1'b0);
		wait_bit(OFS_STATUS_ONE, ST_RX_FULL);
		rd_chk("pin data", OFS_DATA, 32'h96);
		wr(OFS_CONTROL_THR, 32'h0);
		route_pin <= 1'h0;
		$display("test loop done");
	endtask : test_loop

	task automatic test_stop();
		wr(OFS_CONTROL_THR, 32'h10);
		woke = 1'h0;
		wr(OFS_STOP_CTRL, {30'h0, STOP_LIGHT});
		i_remote_serial.pulse_low(40);
		settle();
		chk("light wake", 32'h1, {31'h0, woke});
		rd_chk("back to run", OFS_STOP_CTRL, {30'h0, STOP_RUN});
		rd_chk("light keeps", OFS_BAUD, 32'h1);
		// Wake pulse is still low on resume, so a frame of ones follows
		wait_bit(OFS_STATUS_ONE, ST_RX_FULL);
		rd_chk("resumed rx", OFS_DATA, 32'hFF);
		woke = 1'h0;
		wr(OFS_STOP_CTRL, {30'h0, STOP_MID});
		i_remote_serial.pulse_low(40);
		settle();
		chk("mid no wake", 32'h0, {31'h0, woke});
		wr(OFS_STOP_CTRL, {30'h0, STOP_RUN});
		rd_chk("mid loses", OFS_BAUD, {16'h0, BAUD_RESET});
		wr(OFS_CONTROL_THR, 32'h10);
		wr(OFS_STOP_CTRL, {30'h0, STOP_DEEP});
		wr(OFS_CONTROL_THR, 32'h80);
		wr(OFS_STOP_CTRL, {30'h0, STOP_RUN});
		rd_chk("deep loses", OFS_CONTROL_THR, 32'h0);
		$display("test stop done");
	endtask : test_stop

	initial begin
		repeat (2) @(posedge ref_clk);
		nrst <= 1'h1;
		test_reset();
		test_receive();
		test_overrun();
		test_noise();
		test_loop();
		test_stop();
		complete_run();
	end
endmodule : async_serial_status_loop_modes_tb
